// file: shared/ars_params.svh
// Constants for the analog range scaler: codes, limits, resolution.
// Assumes the includer is a design file of the range scaler.
// Overview of operation
// - Nominal top 27648, overrange to 32511, else 32767
// - 1-5 V: underrange to -4864, then wire break
// - 0-10 V: overflow above 11.759, underflow below -1.759
// - Bipolar voltage: -27648 nominal, -32512 limit, then -32768
// - 80 mV range uses symmetric bipolar mapping
// - 0-20 mA: underrange to -4864, then underflow
// - 4-20 mA: below 1.185 mA reports wire break
// - 20 mA bipolar: symmetric mapping, -32512 then underflow
// - Resistance ranges unipolar, never negative codes
// - Output is 16-bit two's complement, sign bit 15
// - Low resolution left aligned, low bits zero except in the 7FFF codes
`ifndef ARS_PARAMS_SVH
`define ARS_PARAMS_SVH
`define ARS_NOM_POS 17'sh06C00
`define ARS_NOM_NEG -17'sh06C00
`define ARS_OVR_POS 17'sh07EFF
`define ARS_OVR_NEG -17'sh07F00
`define ARS_UNI_UND -17'sh01300
`define ARS_CODE_OVF 16'h7FFF
`define ARS_CODE_UDF 16'h8000
`define ARS_CODE_WB 16'h7FFF
`define ARS_SIGN_BIT 15
`define ARS_RES_BITS 15
`endif

// file: shared/ars_pkg.sv
// Types for the analog range scaler.
// Assumes nothing of its surroundings.
package ars_pkg;
  // Measuring range selections
  typedef enum logic [3:0] {
    ARS_R_1_5V, ARS_R_0_10V, ARS_R_PM5V, ARS_R_PM10V, ARS_R_PM80MV,
    ARS_R_0_20MA, ARS_R_4_20MA, ARS_R_PM20MA,
    ARS_R_150R, ARS_R_300R, ARS_R_600R, ARS_R_3K
  } ars_range_t;
  // Range status classes
  typedef enum logic [2:0] {
    ARS_S_NOMINAL, ARS_S_OVERRANGE, ARS_S_UNDERRANGE,
    ARS_S_OVERFLOW, ARS_S_UNDERFLOW, ARS_S_WIREBREAK
  } ars_status_t;
endpackage

// file: logic/ars_fifo.sv
// Slot for the output FIFO of the analog range scaler.
// The FIFO module sits in the scaler top file, so one file holds the logic.

// file: logic/ars_scaler.sv
// Top of the analog range scaler: classifies, codes, buffers output.
// Assumes raw samples already scaled so nominal top is 27648 counts,
// synchronous inputs, and a sink that may stall.
`timescale 1ns/1ps
`include "ars_params.svh"
module ars_scaler #(
  parameter int RES_BITS = `ARS_RES_BITS,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Range selection, held stable while running
  input wire ars_pkg::ars_range_t range_sel,
  // Converter sample: signed, 27648 counts per nominal span
  input wire logic samp_valid,
  output logic samp_ready,
  input wire logic signed [16:0] samp_raw,
  // Process image output
  output logic val_valid,
  input wire logic val_ready,
  output logic [15:0] val_code,
  output ars_pkg::ars_status_t val_status
);
  // Output register stage after the FIFO
  logic val_valid_r, val_valid_nxt;
  logic [15:0] val_code_r, val_code_nxt;
  ars_pkg::ars_status_t val_status_r, val_status_nxt;
  // Classification results
  logic [15:0] code_c, code_q;
  ars_pkg::ars_status_t stat_c;
  logic bip_c, res_c, wb_c;
  logic [18:0] fifo_in, fifo_out;
  logic fifo_valid, fifo_pop;
  logic [15:0] res_mask;
  // Sample quantised to the converter resolution
  logic signed [16:0] samp_m;

  // Mask of bits kept by the converter resolution
  assign res_mask = 16'hFFFF << (15 - RES_BITS);
  // Classify the quantised value so status and code never disagree
  assign samp_m = samp_raw & {1'b1, res_mask};

  // Range classification and saturation
  always_comb begin
    bip_c = (range_sel == ars_pkg::ARS_R_PM5V) ||
            (range_sel == ars_pkg::ARS_R_PM10V) ||
            (range_sel == ars_pkg::ARS_R_PM80MV) ||
            (range_sel == ars_pkg::ARS_R_PM20MA);
    res_c = (range_sel >= ars_pkg::ARS_R_150R);
    // Live-zero ranges report wire break instead of underflow
    wb_c = (range_sel == ars_pkg::ARS_R_1_5V) ||
           (range_sel == ars_pkg::ARS_R_4_20MA);
    code_c = samp_m[15:0];
    stat_c = ars_pkg::ARS_S_NOMINAL;
    if (samp_m > `ARS_OVR_POS) begin
      code_c = `ARS_CODE_OVF;
      stat_c = ars_pkg::ARS_S_OVERFLOW;
    end else if (samp_m > `ARS_NOM_POS) begin
      stat_c = ars_pkg::ARS_S_OVERRANGE;
    end else if (res_c && samp_m < 17'sh0) begin
      code_c = 16'h0000;
    end else if (bip_c && samp_m < `ARS_OVR_NEG) begin
      code_c = `ARS_CODE_UDF;
      stat_c = ars_pkg::ARS_S_UNDERFLOW;
    end else if (bip_c && samp_m < `ARS_NOM_NEG) begin
      stat_c = ars_pkg::ARS_S_UNDERRANGE;
    end else if (!bip_c && !res_c && samp_m < `ARS_UNI_UND) begin
      if (wb_c) begin
        code_c = `ARS_CODE_WB;
        stat_c = ars_pkg::ARS_S_WIREBREAK;
      end else begin
        code_c = `ARS_CODE_UDF;
        stat_c = ars_pkg::ARS_S_UNDERFLOW;
      end
    end else if (!bip_c && !res_c && samp_m < 17'sh0) begin
      stat_c = ars_pkg::ARS_S_UNDERRANGE;
    end
  end

  assign fifo_in = {stat_c, code_c};

  // Buffer between converter and process image
  ars_fifo #(.WIDTH(19), .DEPTH(DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(samp_valid),
    .in_ready(samp_ready),
    .in_data(fifo_in),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out)
  );

  // Refill output stage when empty or being taken
  assign fifo_pop = !val_valid_r || val_ready;
  assign code_q = fifo_out[15:0];

  // Output stage next state
  always_comb begin
    val_valid_nxt = val_valid_r;
    val_code_nxt = val_code_r;
    val_status_nxt = val_status_r;
    if (fifo_pop) begin
      val_valid_nxt = fifo_valid;
      if (fifo_valid) begin
        val_code_nxt = code_q;
        val_status_nxt = ars_pkg::ars_status_t'(fifo_out[18:16]);
      end
    end
  end

  // Output stage registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      val_valid_r <= 1'b0;
      val_code_r <= 16'h0000;
      val_status_r <= ars_pkg::ARS_S_NOMINAL;
    end else begin
      val_valid_r <= val_valid_nxt;
      val_code_r <= val_code_nxt;
      val_status_r <= val_status_nxt;
    end
  end

  assign val_valid = val_valid_r;
  assign val_code = val_code_r;
  assign val_status = val_status_r;

  // Overflow code tied to overflow status
  a_ovf_code: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    val_valid && val_status == ars_pkg::ARS_S_OVERFLOW |->
    val_code == `ARS_CODE_OVF) else $error("overflow code wrong");
  // Overrange codes stay inside 27649..32511
  a_ovr_span: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    val_valid && val_status == ars_pkg::ARS_S_OVERRANGE |->
    $signed(val_code) > `ARS_NOM_POS && $signed(val_code) <= `ARS_OVR_POS)
    else $error("overrange code out of span");
  // Wire break code value
  a_wb_code: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    val_valid && val_status == ars_pkg::ARS_S_WIREBREAK |->
    val_code == `ARS_CODE_WB) else $error("wire break code wrong");
  // Underflow code value
  a_udf_code: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    val_valid && val_status == ars_pkg::ARS_S_UNDERFLOW |->
    val_code == `ARS_CODE_UDF) else $error("underflow code wrong");
  // Underrange codes negative and no deeper than the bipolar limit
  a_udr_span: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    val_valid && val_status == ars_pkg::ARS_S_UNDERRANGE |->
    val_code[15] && $signed(val_code) >= `ARS_OVR_NEG)
    else $error("underrange code out of span");
  // Unipolar underrange limit
  a_uni_under: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    samp_valid && samp_ready && !bip_c && !res_c &&
    samp_raw < `ARS_UNI_UND |-> stat_c != ars_pkg::ARS_S_UNDERRANGE)
    else $error("unipolar underrange too deep");
  // Bipolar underrange limit
  a_bip_under: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    samp_valid && bip_c && samp_raw < `ARS_OVR_NEG |->
    stat_c == ars_pkg::ARS_S_UNDERFLOW)
    else $error("bipolar underflow missed");
  // Resistance never negative
  a_res_pos: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    samp_valid && res_c |-> !code_c[15] || stat_c ==
    ars_pkg::ARS_S_OVERFLOW) else $error("negative resistance");
  // Unused low bits zero in nominal codes
  a_low_zero: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    val_valid && val_status == ars_pkg::ARS_S_NOMINAL |->
    (val_code & ~res_mask) == 16'h0000)
    else $error("low bits not zero");
  // Accepted sample reaches the output two edges later when empty
  a_pass_thru: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    samp_valid && samp_ready && !val_valid && !fifo_valid |->
    ##2 val_valid) else $error("sample not delivered");
endmodule

// Valid/ready FIFO for the scaled value stream, one clock domain
module ars_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // Storage array, no reset needed
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  // Not-full flag kept in a flop so ready leaves the top unbuffered
  logic in_ready_r, in_ready_nxt;
  logic push, pop;
  // Handshakes and pointer updates
  always_comb begin
    push = in_valid && in_ready_r;
    pop = out_valid && out_ready;
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    // Worked from the next count, so it matches the count register
    in_ready_nxt = (cnt_nxt != (AW+1)'(DEPTH));
  end
  // Full stalls the source, empty hides data
  assign in_ready = in_ready_r;
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  // Register state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      in_ready_r <= 1'b1;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      in_ready_r <= in_ready_nxt;
    end
  end
  // Write port
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
endmodule

// file: bench/ars_sink.sv
// Process image sink model for the analog range scaler.
// Assumes the scaler's clock and reset; stall holds ready low.
`timescale 1ns/1ps
module ars_sink (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Bench control
  input wire logic stall,
  // Process image side
  input wire logic val_valid,
  output logic val_ready,
  input wire logic [15:0] val_code,
  input wire ars_pkg::ars_status_t val_status
);
  // Words taken, oldest first, as code and status
  logic [18:0] got_q[$];
  // Ready lags stall one edge, as a busy sink would
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      val_ready <= 1'h0;
    end else begin
      val_ready <= !stall;
      // Only an edge that sees both high moves a word
      if (val_valid && val_ready) begin
        got_q.push_back({val_code, val_status});
      end
    end
  end
endmodule

// file: bench/test_analog_range_scaler.sv
// Self-checking bench for the analog range scaler.
// Assumes ars_sink on the output side and a single clock.
`timescale 1ns/1ps
module test_analog_range_scaler;
  // Stimulus
  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  logic stall = 1'h0;
  logic samp_valid = 1'h0;
  logic signed [16:0] samp_raw = 17'h00000;
  ars_pkg::ars_range_t range_sel = ars_pkg::ARS_R_1_5V;
  // Design outputs
  logic samp_ready;
  logic val_valid;
  logic val_ready;
  logic [15:0] val_code;
  ars_pkg::ars_status_t val_status;
  // Low resolution copy of the design
  logic lo_ready;
  logic lo_valid;
  logic [15:0] lo_code;
  logic [15:0] lo_q[$];
  // Scoreboard
  int failures = 0;
  int tests_run = 0;
  int n;
  logic [18:0] w;

  // 40 MHz clock
  always #12.5 core_clk = !core_clk;

  ars_scaler #(.RES_BITS(15), .DEPTH(32)) DUT (.core_clk(core_clk),
    .rst_n(rst_n), .range_sel(range_sel), .samp_valid(samp_valid),
    .samp_ready(samp_ready), .samp_raw(samp_raw), .val_valid(val_valid),
    .val_ready(val_ready), .val_code(val_code), .val_status(val_status));
  ars_scaler #(.RES_BITS(12), .DEPTH(32)) DUT_LO (.core_clk(core_clk),
    .rst_n(rst_n), .range_sel(range_sel), .samp_valid(samp_valid),
    .samp_ready(lo_ready), .samp_raw(samp_raw), .val_valid(lo_valid),
    .val_ready(val_ready), .val_code(lo_code), .val_status());
  // Low resolution words move on the same sink handshake
  always @(posedge core_clk) begin
    if (rst_n && lo_valid && val_ready) begin
      lo_q.push_back(lo_code);
    end
  end
  ars_sink snk (.core_clk(core_clk), .rst_n(rst_n), .stall(stall),
    .val_valid(val_valid), .val_ready(val_ready), .val_code(val_code),
    .val_status(val_status));

  // Compare and count
  task automatic check(input logic [18:0] got, input logic [18:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic stop_test();
    if (failures == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Bounded wait step; a hang counts as a mismatch
  task automatic tick(inout int k);
    k++;
    if (k > 200) begin
      check(19'h00001, 19'h00000);
      stop_test();
    end
  endtask

  // Offer one sample, held until an edge that takes it
  task automatic send(input logic signed [16:0] raw);
    int k = 0;
    samp_raw = raw;
    samp_valid = 1'h1;
    @(negedge core_clk);
    while (!samp_ready) begin
      tick(k);
      @(negedge core_clk);
    end
    @(posedge core_clk);
    #1;
    samp_valid = 1'h0;
  endtask

  // Pop the next word the sink took
  task automatic take(output logic [18:0] got);
    int k = 0;
    while (snk.got_q.size() == 0) begin
      @(posedge core_clk);
      tick(k);
    end
    got = snk.got_q.pop_front();
  endtask

  // One sample in one range; code and status judged
  task automatic t(input int r, input logic signed [16:0] raw,
                   input logic [15:0] c, input logic [2:0] s);
    @(posedge core_clk);
    #1;
    range_sel = ars_pkg::ars_range_t'(r);
    send(raw);
    take(w);
    check(w, {c, s});
    #1;
    check(19'(lo_q.size()), 19'h00001);
    check(19'(lo_q.pop_front()), 19'(s > 3'h2 ? c : c & 16'hFFF8));
  endtask

  // Fill with the sink stalled until refused, then drain in order
  task automatic fill_drain();
    int k = 0;
    int i;
    @(posedge core_clk);
    #1;
    stall = 1'h1;
    range_sel = ars_pkg::ARS_R_0_10V;
    n = 0;
    samp_raw = 17'h00000;
    samp_valid = 1'h1;
    @(negedge core_clk);
    while (samp_ready) begin
      @(posedge core_clk);
      #1;
      n++;
      samp_raw = 17'(n);
      tick(k);
      @(negedge core_clk);
    end
    check(19'(lo_ready), 19'h00000);
    @(posedge core_clk);
    #1;
    samp_valid = 1'h0;
    check(19'(n >= 32), 19'h00001);
    check(19'(snk.got_q.size()), 19'h00000);
    stall = 1'h0;
    for (i = 0; i < n; i++) begin
      take(w);
      check(w, {16'(i), 3'h0});
      #1;
      check(19'(lo_q.pop_front()), 19'(16'(i) & 16'hFFF8));
    end
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    #1;
    rst_n = 1'h1;
    @(posedge core_clk);
    #1;
    t(0, 17'h06C00, 16'h6C00, 3'h0);
    t(0, 17'h06C01, 16'h6C01, 3'h1);
    t(0, 17'h07EFF, 16'h7EFF, 3'h1);
    t(0, 17'h07F00, 16'h7FFF, 3'h3);
    t(0, 17'h1ED00, 16'hED00, 3'h2);
    t(0, 17'h1ECFF, 16'h7FFF, 3'h5);
    t(1, 17'h05100, 16'h5100, 3'h0);
    t(1, 17'h1ECFF, 16'h8000, 3'h4);
    t(2, 17'h19400, 16'h9400, 3'h0);
    t(3, 17'h193FF, 16'h93FF, 3'h2);
    t(3, 17'h18100, 16'h8100, 3'h2);
    t(2, 17'h180FF, 16'h8000, 3'h4);
    t(4, 17'h07F00, 16'h7FFF, 3'h3);
    t(4, 17'h180FF, 16'h8000, 3'h4);
    t(5, 17'h1FFFF, 16'hFFFF, 3'h2);
    t(5, 17'h1ECFF, 16'h8000, 3'h4);
    t(6, 17'h1ED00, 16'hED00, 3'h2);
    t(6, 17'h1ECFF, 16'h7FFF, 3'h5);
    t(7, 17'h193FF, 16'h93FF, 3'h2);
    t(7, 17'h180FF, 16'h8000, 3'h4);
    t(8, 17'h1FFFF, 16'h0000, 3'h0);
    t(9, 17'h07EFF, 16'h7EFF, 3'h1);
    t(10, 17'h07F00, 16'h7FFF, 3'h3);
    t(11, 17'h00001, 16'h0001, 3'h0);
    fill_drain();
    stop_test();
  end
endmodule
